// ### inc/lvm_pkg.sv
// Purpose: constants and types for the supply monitor control block
// Assumes: classic wishbone slave, 32-bit data, word-aligned registers
// Notes: all offsets are byte addresses
// Operation
// - monitor idle after reset; supervises only once power-disable is cleared
// - active monitor with reset-disable clear requests reset on low supply
// - stop-enable keeps monitor running in stop; may wake by reset or irq
// - two-bit trip select picks 5 V or 3.3 V threshold
// - low output sets below falling level, clears above rising, else holds
// - irq flag sets on every change of low output bit
// - irq request while flag and enable both set
// - writing 1 to ack clears flag; 0 no effect; ack reads 0
// - reset clears irq enable and irq flag
// - triggered reset held until supply rises above rising level
// - reset has priority over irq; irq enable cleared on reset
// - monitor reset also drives external reset pin low while held
// - when enabled monitor stays active in wait and can wake device
package lvm_pkg;
  localparam logic [3:0] LVM_STATUS_OFS = 4'h0;
  localparam logic [3:0] LVM_CONFIG_OFS = 4'h4;
  localparam logic [3:0] LVM_IRQ_CLR_OFS = 4'h8;
  localparam logic [3:0] LVM_IRQ_EN_OFS = 4'hC;
  // status / control register bit positions
  localparam int LVM_ST_OUT_BIT = 4;
  localparam int LVM_ST_IE_BIT = 3;
  localparam int LVM_ST_IF_BIT = 2;
  localparam int LVM_ST_ACK_BIT = 1;
  // config register bit positions
  localparam int LVM_CF_PWRD_BIT = 0;
  localparam int LVM_CF_RSTD_BIT = 1;
  localparam int LVM_CF_STOP_BIT = 2;
  localparam int LVM_CF_SEL_LSB = 4;
  // event bits: 0 = low output toggled, 1 = monitor reset started
  localparam int LVM_EV_W = 2;
  localparam logic LVM_PWRD_RST = 1'b1;
  localparam logic LVM_RSTD_RST = 1'b1;
  localparam logic LVM_STOP_RST = 1'b0;
  localparam logic [1:0] LVM_SEL_RST = 2'h0;

  typedef enum logic [1:0] {LVM_RUN, LVM_HOLD} lvm_rst_e;

  typedef struct packed {
    logic pwr_disable;
    logic rst_disable;
    logic stop_enable;
    logic [1:0] trip_sel;
  } lvm_cfg_s;

  typedef struct packed {
    lvm_cfg_s cfg;
    logic cmp_f_s1;
    logic cmp_f_s2;
    logic cmp_r_s1;
    logic cmp_r_s2;
    logic low_out;
    logic irq_en;
    logic irq_flag;
    lvm_rst_e rst_state;
    logic [LVM_EV_W-1:0] ev_status;
    logic [LVM_EV_W-1:0] ev_enable;
    logic ev_irq;
    logic sup_irq;
    logic rst_req;
    logic rst_pin_oe;
    logic [1:0] trip_sel_out;
    logic cmp_enable;
    logic ack;
    logic [31:0] dat;
  } lvm_state_s;
endpackage

// ### rtl/lvm_ctrl.sv
// Purpose: digital control around the supply comparator
// Assumes: comparator outputs are asynchronous, one clock domain
// Notes: reset pin is open drain; oe high pulls it low
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ns
module lvm_ctrl
  import lvm_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // comparator and power modes
  input wire logic below_falling_i,
  input wire logic above_rising_i,
  input wire logic stop_mode_i,
  output logic cmp_enable_o,
  output logic [1:0] trip_level_select_o,
  // reset and interrupts
  output logic sys_reset_req_o,
  output logic rst_pin_o,
  output logic rst_pin_oe_o,
  output logic supply_irq_o,
  output logic event_irq_o
);
  lvm_state_s s_reg;
  lvm_state_s s_next;

  function automatic logic [31:0] rd_mux(input lvm_state_s s, input logic [3:0] a);
    logic [31:0] d;
    d = 32'h0;
    case (a)
      LVM_STATUS_OFS: begin
        d[LVM_ST_OUT_BIT] = s.low_out;
        d[LVM_ST_IE_BIT] = s.irq_en;
        d[LVM_ST_IF_BIT] = s.irq_flag;
        d[LVM_ST_ACK_BIT] = 1'b0;
        d[8 +: LVM_EV_W] = s.ev_status;
      end
      LVM_CONFIG_OFS: begin
        d[LVM_CF_PWRD_BIT] = s.cfg.pwr_disable;
        d[LVM_CF_RSTD_BIT] = s.cfg.rst_disable;
        d[LVM_CF_STOP_BIT] = s.cfg.stop_enable;
        d[LVM_CF_SEL_LSB +: 2] = s.cfg.trip_sel;
      end
      LVM_IRQ_EN_OFS: d[LVM_EV_W-1:0] = s.ev_enable;
      default: d = 32'h0;
    endcase
    return d;
  endfunction

  logic active;
  logic wr;
  logic fall_s;
  logic rise_s;
  logic [LVM_EV_W-1:0] ev;

  always_comb begin
    s_next = s_reg;
    // stop mode halts the monitor unless stop-enable is set
    active = !s_reg.cfg.pwr_disable && (!stop_mode_i || s_reg.cfg.stop_enable);
    wr = cyc_i && stb_i && we_i && !s_reg.ack;
    fall_s = s_reg.cmp_f_s2;
    rise_s = s_reg.cmp_r_s2;
    ev = '0;
    // only the second flop is read downstream
    s_next.cmp_f_s1 = below_falling_i;
    s_next.cmp_f_s2 = s_reg.cmp_f_s1;
    s_next.cmp_r_s1 = above_rising_i;
    s_next.cmp_r_s2 = s_reg.cmp_r_s1;
    s_next.cmp_enable = active;
    s_next.trip_sel_out = s_reg.cfg.trip_sel;
    // bus: one-cycle ack, dropped the cycle after
    s_next.ack = cyc_i && stb_i && !s_reg.ack;
    s_next.dat = (cyc_i && stb_i && !we_i && !s_reg.ack) ? rd_mux(s_reg, adr_i) : 32'h0;
    if (wr && sel_i[0]) begin
      case (adr_i)
        LVM_STATUS_OFS: begin
          s_next.irq_en = dat_i[LVM_ST_IE_BIT];
          if (dat_i[LVM_ST_ACK_BIT]) begin
            s_next.irq_flag = 1'b0;
          end
        end
        LVM_CONFIG_OFS: begin
          s_next.cfg.pwr_disable = dat_i[LVM_CF_PWRD_BIT];
          s_next.cfg.rst_disable = dat_i[LVM_CF_RSTD_BIT];
          s_next.cfg.stop_enable = dat_i[LVM_CF_STOP_BIT];
          s_next.cfg.trip_sel = dat_i[LVM_CF_SEL_LSB +: 2];
        end
        LVM_IRQ_CLR_OFS: s_next.ev_status = s_reg.ev_status & ~dat_i[LVM_EV_W-1:0];
        LVM_IRQ_EN_OFS: s_next.ev_enable = dat_i[LVM_EV_W-1:0];
        default: ;
      endcase
    end
    // hysteresis: between levels the bit holds
    if (active) begin
      if (fall_s) begin
        s_next.low_out = 1'b1;
      end else if (rise_s) begin
        s_next.low_out = 1'b0;
      end
    end
    if (s_next.low_out != s_reg.low_out) begin
      ev[0] = 1'b1;
      s_next.irq_flag = 1'b1; // set wins over ack
    end
    case (s_reg.rst_state)
      LVM_RUN: begin
        if (active && !s_reg.cfg.rst_disable && fall_s) begin
          s_next.rst_state = LVM_HOLD;
          s_next.irq_en = 1'b0;
          ev[1] = 1'b1;
        end
      end
      LVM_HOLD: begin
        if (rise_s) begin
          s_next.rst_state = LVM_RUN;
        end
      end
      default: s_next.rst_state = LVM_RUN;
    endcase
    // reset outranks irq: no request while reset is held
    s_next.sup_irq = s_next.irq_flag && s_next.irq_en && (s_next.rst_state == LVM_RUN);
    s_next.rst_req = (s_next.rst_state == LVM_HOLD);
    s_next.rst_pin_oe = (s_next.rst_state == LVM_HOLD);
    s_next.ev_status = s_next.ev_status | ev;
    s_next.ev_irq = |(s_next.ev_status & s_next.ev_enable);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.cfg.pwr_disable <= LVM_PWRD_RST;
      s_reg.cfg.rst_disable <= LVM_RSTD_RST;
      s_reg.cfg.stop_enable <= LVM_STOP_RST;
      s_reg.cfg.trip_sel <= LVM_SEL_RST;
      s_reg.rst_state <= LVM_RUN;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign dat_o = s_reg.dat;
  assign ack_o = s_reg.ack;
  assign cmp_enable_o = s_reg.cmp_enable;
  assign trip_level_select_o = s_reg.trip_sel_out;
  assign sys_reset_req_o = s_reg.rst_req;
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe_o = s_reg.rst_pin_oe;
  assign supply_irq_o = s_reg.sup_irq;
  assign event_irq_o = s_reg.ev_irq;
endmodule

// ### test/lvm_supply_model.sv
// Purpose: comparator model for the supply monitor
// Assumes: level 0 below falling, 1 in band, 2 above rising
// Notes: delayed so edges land off the clock
`timescale 1ns/1ns
module lvm_supply_model (
  // supply level
  input wire logic [1:0] level_i,
  // comparator outputs
  output logic below_falling_o,
  output logic above_rising_o
);
  // inside the band neither side trips, so the block must hold state
  assign #37 below_falling_o = (level_i == 2'h0);
  assign #37 above_rising_o = (level_i == 2'h2);
endmodule

// ### test/lvm_ctrl_properties.sv
// Purpose: port assertions for lvm_ctrl
// Assumes: one clock, sync reset
// Notes: bounds follow the hand-over latencies
`timescale 1ns/1ns
module lvm_ctrl_chk (
  input wire logic clk_i, rst_i, ce_i, cyc_i, stb_i, ack_o,
  input wire logic below_falling_i, above_rising_i, cmp_enable_o,
  input wire logic sys_reset_req_o, rst_pin_o, rst_pin_oe_o, supply_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_quiet_rise;
    (!below_falling_i)[*4] ##1 below_falling_i;
  endsequence
  sequence s_held_low;
    (sys_reset_req_o && !above_rising_i)[*5];
  endsequence
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
    else $error("bus not answered");
  chk_ack_drop: assert property (ack_o && ce_i |=> !ack_o) else $error("ack held");
  chk_sync_delay: assert property (s_quiet_rise |=> (!$rose(sys_reset_req_o))[*2])
    else $error("reset before sync");
  chk_rst_cause: assert property ($rose(sys_reset_req_o) |-> $past(cmp_enable_o))
    else $error("reset while idle");
  chk_hold_keep: assert property (s_held_low |=> sys_reset_req_o)
    else $error("hold lost");
  chk_pin_follow: assert property (rst_pin_oe_o == sys_reset_req_o && !rst_pin_o)
    else $error("pin off");
  chk_irq_yield: assert property ($rose(sys_reset_req_o) |=> (!supply_irq_o)[*3])
    else $error("irq in reset");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !supply_irq_o && !cmp_enable_o)
    else $error("not cleared");
endmodule
bind lvm_ctrl lvm_ctrl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .below_falling_i(below_falling_i), .above_rising_i(above_rising_i),
  .cmp_enable_o(cmp_enable_o), .sys_reset_req_o(sys_reset_req_o), .rst_pin_o(rst_pin_o),
  .rst_pin_oe_o(rst_pin_oe_o), .supply_irq_o(supply_irq_o));

// ### test/low_voltage_monitor_ctrl_tb.sv
// Purpose: register-level test of lvm_ctrl
// Assumes: wishbone ack one cycle after request
// Notes: sel_i tied on; ce_i held on except for one stretch near the end
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("mismatch %0t %h", $time, a); end end
module low_voltage_monitor_ctrl_tb import lvm_pkg::*;;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, stop = 0, ce = 1;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0, q;
  logic [1:0] lvl = 2'h2;
  logic [31:0] dat_o;
  logic [1:0] tsel;
  logic ack_o, below, above, cmp_en, rreq, pin, pin_oe, sirq, eirq;
  int failures = 0, compares = 0;
  always #50 clk_i = ~clk_i;
  lvm_supply_model cmp (.level_i(lvl), .below_falling_o(below), .above_rising_o(above));
  lvm_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .below_falling_i(below), .above_rising_i(above), .stop_mode_i(stop), .cmp_enable_o(cmp_en),
    .trip_level_select_o(tsel), .sys_reset_req_o(rreq), .rst_pin_o(pin),
    .rst_pin_oe_o(pin_oe), .supply_irq_o(sirq), .event_irq_o(eirq));
  task conclude;
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack_o !== 1'b1) begin failures++; conclude; end
  endtask
  task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(q & m, e)
  endtask
  // fixed settle time covers sync plus registered outputs
  task tick; repeat (8) @(posedge clk_i); endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(LVM_STATUS_OFS, 32'hFFFF, 32'h0);
    rd(LVM_CONFIG_OFS, 32'h37, 32'h3);
    wb(1'b1, LVM_CONFIG_OFS, 32'h23);
    tick;
    `CHK({tsel, cmp_en}, 3'h4)
    wb(1'b1, LVM_CONFIG_OFS, 32'h22);
    tick;
    `CHK(cmp_en, 1'b1)
    wb(1'b1, LVM_STATUS_OFS, 32'h08);
    lvl <= 2'h0;
    tick;
    rd(LVM_STATUS_OFS, 32'h1F, 32'h1C);
    `CHK({sirq, rreq}, 2'h2)
    wb(1'b1, LVM_STATUS_OFS, 32'h0A);
    rd(LVM_STATUS_OFS, 32'h1F, 32'h18);
    lvl <= 2'h1;
    tick;
    rd(LVM_STATUS_OFS, 32'h1F, 32'h18);
    `CHK(sirq, 1'b0)
    lvl <= 2'h2;
    tick;
    wb(1'b1, LVM_STATUS_OFS, 32'h08);
    rd(LVM_STATUS_OFS, 32'h1F, 32'h0C);
    wb(1'b1, LVM_STATUS_OFS, 32'h0A);
    stop <= 1'b1;
    tick;
    `CHK(cmp_en, 1'b0)
    wb(1'b1, LVM_CONFIG_OFS, 32'h26);
    tick;
    `CHK(cmp_en, 1'b1)
    stop <= 1'b0;
    wb(1'b1, LVM_CONFIG_OFS, 32'h20);
    lvl <= 2'h0;
    tick;
    `CHK({rreq, pin_oe, pin, sirq}, 4'hC)
    rd(LVM_STATUS_OFS, 32'h08, 32'h0);
    lvl <= 2'h1;
    tick;
    `CHK(rreq, 1'b1)
    lvl <= 2'h2;
    tick;
    `CHK({rreq, pin_oe, eirq}, 3'h0)
    wb(1'b1, LVM_IRQ_EN_OFS, 32'h2);
    tick;
    `CHK(eirq, 1'b1)
    wb(1'b1, LVM_IRQ_CLR_OFS, 32'h3);
    tick;
    `CHK(eirq, 1'b0)
    rd(LVM_STATUS_OFS, 32'h300, 32'h0);
    rd(4'h2, 32'hFFFFFFFF, 32'h0);
    // clock enable low must freeze the synchroniser so no reset is requested until it returns
    ce <= 1'b0;
    lvl <= 2'h0;
    tick;
    `CHK(rreq, 1'b0)
    ce <= 1'b1;
    tick;
    `CHK({rreq, pin_oe}, 2'h3)
    conclude;
  end
endmodule
